// >>> design/capacity_gauge_register_bank.sv
// capacity accounting and register bank of the charge gauge
module capacity_gauge_register_bank
  import gauge_pkg::*;
#(
  parameter int unsigned OVERLOAD_FLAG_CYCLES = 32'(OVERLOAD_FLAG_HOLD_CYC),
  parameter int unsigned SAMPLE_CYCLES = 32'(VSAMPLE_CYC)
) (
  input wire logic ref_clk, // device clock
  input wire logic reset, // async, active high
  input wire logic clk_en, // freezes all state while low
  input wire logic soft_reset, // software reset request, one-cycle pulse
  input wire logic charge_pulse, // one charge count quantum, pin domain
  input wire logic discharge_pulse, // one discharge count quantum, pin domain
  input wire logic self_dis_pulse, // self-discharge decrement request
  input wire logic above_charge_thresh, // offset-corrected sense above valid level, pin
  input wire logic [2:0] rate_class, // measured discharge regime, pin domain
  input wire logic temp_below_zero, // temperature under 0C
  input wire logic temp_below_ten, // temperature under 10C
  input wire logic [7:0] cell_sample, // digitised cell voltage
  input wire logic [7:0] rate_comp_count, // count after rate compensation
  input wire logic [7:0] temp_comp_count, // rate value after temperature compensation
  input wire logic [4:0] seg_pulldown, // pull-down seen on segments 1..5
  input wire logic [4:0] seg_pullup, // pull-up seen on segments 1..5
  input wire logic [7:0] programmed_full_count, // full count from program pins
  input wire logic reg_wr, // host write strobe
  input wire logic [5:0] reg_addr, // host register address
  input wire logic [7:0] reg_wdata, // host write data
  output logic [7:0] reg_rdata_q, // host read data, registered
  output logic first_empty_warning_q, // first empty warning
  output logic final_empty_warning_q, // final empty warning
  output logic learned_value_stale_flag_q, // stale-capacity flag
  output logic valid_discharge_flag_q // valid discharge tracking flag
);
  // ==========================================================
  // input synchronisers
  logic [12:0] sync1_q, sync2_q;
  logic chg_d1_q, dis_d1_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      chg_d1_q <= 1'b0;
      dis_d1_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= {cell_sample[0], temp_below_ten, temp_below_zero, self_dis_pulse,
                  rate_class, above_charge_thresh, discharge_pulse, charge_pulse,
                  3'h0};
      sync2_q <= sync1_q;
      chg_d1_q <= sync2_q[3];
      dis_d1_q <= sync2_q[4];
    end
  end
  logic chg_evt, dis_evt, sd_evt, chg_valid, cold0, cold10;
  logic [2:0] rate_s;
  assign chg_evt = sync2_q[3] & ~chg_d1_q;
  assign dis_evt = sync2_q[4] & ~dis_d1_q;
  assign rate_s = sync2_q[8:6];
  assign sd_evt = sync2_q[9];
  assign cold0 = sync2_q[10];
  assign cold10 = sync2_q[11];
  // discharge activity cancels a valid charge
  assign chg_valid = chg_evt & sync2_q[5] & ~dis_evt;
  // slow multibit buses: two-stage synchronised as whole words
  logic [7:0] cell1_q, cell2_q, rc1_q, rc2_q, tc1_q, tc2_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cell1_q <= '0;
      cell2_q <= '0;
      rc1_q <= '0;
      rc2_q <= '0;
      tc1_q <= '0;
      tc2_q <= '0;
    end else if (clk_en) begin
      cell1_q <= cell_sample;
      cell2_q <= cell1_q;
      rc1_q <= rate_comp_count;
      rc2_q <= rc1_q;
      tc1_q <= temp_comp_count;
      tc2_q <= tc1_q;
    end
  end

  // ==========================================================
  // software reset and 0.94 scaling
  logic dev_rst;
  assign dev_rst = soft_reset;
  function automatic logic [7:0] scale94(input logic [7:0] v);
    logic [15:0] p;
    p = 16'(v) * 16'h00F0;
    return p[15:8];
  endfunction

  // ==========================================================
  // available charge count
  logic [15:0] nac_q;
  logic [7:0] learned_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      nac_q <= '0;
    end else if (clk_en) begin
      if (dev_rst) begin
        nac_q <= '0;
      end else if (reg_wr && reg_addr == ADDR_NAC_HIGH) begin
        nac_q[15:8] <= reg_wdata;
      end else if (reg_wr && reg_addr == ADDR_NAC_LOW) begin
        nac_q[7:0] <= reg_wdata;
      end else if (chg_valid && nac_q != 16'hFFFF) begin
        nac_q <= nac_q + 16'h0001;
      end else if ((dis_evt || sd_evt) && nac_q != 16'h0000) begin
        nac_q <= nac_q - 16'h0001;
      end
    end
  end
  logic at_full, above94;
  assign at_full = nac_q[15:8] == learned_q;
  assign above94 = nac_q[15:8] > scale94(learned_q);

  // ==========================================================
  // discharge tally, valid discharge flag and learning
  logic [7:0] tally_q, sd_start_q, charges_q;
  logic learn_evt, stale_q, empty_trip, final_trip;
  assign learn_evt = chg_valid & first_empty_warning_q & valid_discharge_flag_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      valid_discharge_flag_q <= 1'b0;
      tally_q <= '0;
      sd_start_q <= '0;
    end else if (clk_en) begin
      if (dev_rst || learn_evt) begin
        valid_discharge_flag_q <= 1'b0;
      end else if (dis_evt && at_full) begin
        valid_discharge_flag_q <= 1'b1;
        tally_q <= '0;
        sd_start_q <= nac_q[15:8];
      end else if (valid_discharge_flag_q) begin
        if (chg_valid && !first_empty_warning_q) begin
          valid_discharge_flag_q <= 1'b0;
        end else if (nac_q[15:8] < scale94(sd_start_q) && sd_evt) begin
          valid_discharge_flag_q <= 1'b0;
        end else if (cold0 && !first_empty_warning_q && empty_trip) begin
          valid_discharge_flag_q <= 1'b0;
        end else if (dis_evt && !first_empty_warning_q && tally_q != COUNT_MAX) begin
          tally_q <= tally_q + 8'h01;
        end
      end
    end
  end
  logic learn_write;
  assign learn_write = reg_wr && reg_addr == ADDR_LEARNED;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      learned_q <= '0;
    end else if (clk_en) begin
      if (dev_rst) begin
        learned_q <= programmed_full_count;
      end else if (learn_write) begin
        learned_q <= reg_wdata;
      end else if (learn_evt) begin
        if (tally_q < scale94(learned_q)) begin
          learned_q <= scale94(learned_q);
        end else begin
          learned_q <= tally_q;
        end
      end
    end
  end

  // ==========================================================
  // charge cycle counter and stale flag
  logic cpi_armed_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      charges_q <= '0;
      stale_q <= 1'b1;
      cpi_armed_q <= 1'b1;
    end else if (clk_en) begin
      if (dev_rst) begin
        charges_q <= '0;
        stale_q <= 1'b1;
        cpi_armed_q <= 1'b1;
      end else if (learn_evt) begin
        charges_q <= '0;
        stale_q <= 1'b0;
      end else begin
        if (!above94) begin
          cpi_armed_q <= 1'b1;
        end
        if (chg_valid && (cpi_armed_q || !above94)) begin
          if (charges_q != COUNT_MAX) begin
            charges_q <= charges_q + 8'h01;
          end
          if (charges_q + 8'h01 == STALE_AT) begin
            stale_q <= 1'b1;
          end
          if (above94) begin
            cpi_armed_q <= 1'b0;
          end
        end
      end
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      learned_value_stale_flag_q <= 1'b1;
    end else if (clk_en) begin
      learned_value_stale_flag_q <= stale_q;
    end
  end

  // ==========================================================
  // rate flags, overload and empty warnings
  logic [2:0] rate_q;
  logic overload_q, vq_q;
  logic [31:0] overload_flag_cnt_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rate_q <= RATE_LOW;
      overload_q <= 1'b0;
      overload_flag_cnt_q <= '0;
    end else if (clk_en) begin
      rate_q <= rate_s;
      if (rate_s == RATE_HIGH) begin
        overload_q <= 1'b1;
        overload_flag_cnt_q <= OVERLOAD_FLAG_CYCLES;
      end else if (overload_flag_cnt_q > 32'd1) begin
        overload_flag_cnt_q <= overload_flag_cnt_q - 32'd1;
      end else begin
        overload_flag_cnt_q <= '0;
        overload_q <= 1'b0;
      end
    end
  end
  // sampling runs about once per second; overload suspends empty detection
  logic [31:0] samp_cnt_q;
  logic [7:0] cell_q, thresh_q;
  assign empty_trip = cell_q < thresh_q;
  assign final_trip = cell_q < (thresh_q - FINAL_OFFSET);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      samp_cnt_q <= '0;
      cell_q <= '0;
    end else if (clk_en) begin
      if (samp_cnt_q >= SAMPLE_CYCLES - 1) begin
        samp_cnt_q <= '0;
        cell_q <= cell2_q;
      end else begin
        samp_cnt_q <= samp_cnt_q + 32'd1;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      first_empty_warning_q <= 1'b0;
      final_empty_warning_q <= 1'b0;
    end else if (clk_en) begin
      if (dev_rst || chg_valid) begin
        first_empty_warning_q <= 1'b0;
        final_empty_warning_q <= 1'b0;
      end
      if (!dev_rst && !overload_q && rate_q != RATE_HIGH) begin
        if (empty_trip) first_empty_warning_q <= 1'b1;
        if (empty_trip && final_trip) final_empty_warning_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      vq_q <= 1'b0;
    end else if (clk_en) begin
      if (dev_rst || (dis_evt && at_full)) begin
        vq_q <= 1'b0;
      end else if (chg_valid) begin
        vq_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // host storage, compensated capacities
  logic [7:0] pack_tag_q, rate_cap_q, temp_cap_q;
  always_ff @(posedge ref_clk) begin
    if (clk_en && reg_wr && reg_addr == ADDR_PACK_TAG) begin
      pack_tag_q <= reg_wdata;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      thresh_q <= THRESH_RESET;
    end else if (clk_en) begin
      if (dev_rst) thresh_q <= THRESH_RESET;
      else if (reg_wr && reg_addr == ADDR_THRESH) thresh_q <= reg_wdata;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rate_cap_q <= '0;
      temp_cap_q <= '0;
    end else if (clk_en) begin
      if (dev_rst) begin
        rate_cap_q <= '0;
      end else if (chg_valid) begin
        rate_cap_q <= nac_q[15:8];
      end else if (rc2_q < rate_cap_q) begin
        rate_cap_q <= rc2_q;
      end
      // the host read port returns this; never above the rate value held in the cycle before
      temp_cap_q <= (cold10 && tc2_q < rate_cap_q) ? tc2_q : rate_cap_q;
    end
  end

  // ==========================================================
  // host read port
  logic [7:0] flags2;
  assign flags2 = {1'b0, rate_q, sync2_q[5], vq_q, 1'b0, overload_q};
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= '0;
    end else if (clk_en) begin
      case (reg_addr)
        ADDR_NAC_HIGH: reg_rdata_q <= nac_q[15:8];
        ADDR_NAC_LOW: reg_rdata_q <= nac_q[7:0];
        ADDR_PACK_TAG: reg_rdata_q <= pack_tag_q;
        ADDR_LEARNED: reg_rdata_q <= learned_q;
        ADDR_FLAGS2: reg_rdata_q <= flags2;
        ADDR_PULLDOWN: reg_rdata_q <= {3'h0, seg_pulldown};
        ADDR_PULLUP: reg_rdata_q <= {3'h0, seg_pullup};
        ADDR_CHARGES: reg_rdata_q <= charges_q;
        ADDR_CELL_V: reg_rdata_q <= cell_q;
        ADDR_THRESH: reg_rdata_q <= thresh_q;
        ADDR_TEMP_CAP: reg_rdata_q <= temp_cap_q;
        ADDR_RATE_CAP: reg_rdata_q <= rate_cap_q;
        default: reg_rdata_q <= ZERO_RESET;
      endcase
    end
  end
endmodule // capacity_gauge_register_bank

// >>> design/gauge_pkg.sv
// constants, register map and encodings for the capacity gauge register bank
// Notes on behaviour
// - available count rises on valid charge, falls on discharge and self-discharge.
// - any reset clears both bytes of the available count.
// - pack-type tag is plain host storage with no effect on behaviour.
// - software reset loads learned capacity with the program-pin full count; hardware reset loads zero.
// - with valid discharge set, first valid charge after empty warning loads tally.
// - tally below 0.94 of capacity gives 0.94 times previous capacity instead.
// - rate bits 6..4 show 000 below 0.5C, 001 to 2C, 010 above.
// - bit 2 sets on valid charge, clears on first discharge from full.
// - overload follows rate above 2C, clears 0.5 s later; blocks empty sampling.
// - pull-down register bit n-1 marks pull-down on segment n; bits 7..5 reserved.
// - pull-up register bit n-1 marks pull-up on segment n; bits 7..5 reserved.
// - learning needs full-to-empty discharge, no charge, temp >= 0C, self-discharge <= 6%.
// - charge count steps per valid charge, once only while count above 0.94 capacity.
// - charge count saturates at 255; stale flag set on reaching 64.
// - a learned-capacity update by learning clears the charge count and the stale flag; a host write clears neither.
// - cell voltage reading refreshed about once per second.
// - threshold sets first empty point; final point 25mV lower; resets to A2h.
// - rate-compensated value only falls in discharge, tracks count in charge.
// - temp-compensated value derives from rate value, lower below 10C.
// - charge is valid only above threshold; discharge cancels valid charge.
// - first empty warning latches on low voltage under 2C until valid charge.
package gauge_pkg;
  // ==========================================================
  // register offsets
  localparam logic [5:0] ADDR_NAC_HIGH = 6'h03;
  localparam logic [5:0] ADDR_PACK_TAG = 6'h04;
  localparam logic [5:0] ADDR_LEARNED = 6'h05;
  localparam logic [5:0] ADDR_FLAGS2 = 6'h06;
  localparam logic [5:0] ADDR_PULLDOWN = 6'h07;
  localparam logic [5:0] ADDR_PULLUP = 6'h08;
  localparam logic [5:0] ADDR_CHARGES = 6'h09;
  localparam logic [5:0] ADDR_CELL_V = 6'h0B;
  localparam logic [5:0] ADDR_THRESH = 6'h0C;
  localparam logic [5:0] ADDR_TEMP_CAP = 6'h0D;
  localparam logic [5:0] ADDR_RATE_CAP = 6'h0E;
  localparam logic [5:0] ADDR_NAC_LOW = 6'h17;
  // ==========================================================
  // field positions and reset values
  localparam int FLAG_RATE_LSB = 4;
  localparam int FLAG_TEST_BIT = 3;
  localparam int FLAG_VALID_CHG = 2;
  localparam int FLAG_OVERLOAD = 0;
  localparam logic [7:0] THRESH_RESET = 8'hA2;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] STALE_AT = 8'h40;
  localparam logic [7:0] FINAL_OFFSET = 8'h05; // 25mV at 1.2V/256 per step, rounded
  localparam logic [2:0] RATE_LOW = 3'h0;
  localparam logic [2:0] RATE_MID = 3'h1;
  localparam logic [2:0] RATE_HIGH = 3'h2;
  // ==========================================================
  // timing
  localparam longint CLK_HZ = 125000000;
  localparam int OVERLOAD_FLAG_HOLD_MS = 500;
  localparam int VSAMPLE_MS = 1000;
  localparam longint OVERLOAD_FLAG_HOLD_CYC = CLK_HZ * OVERLOAD_FLAG_HOLD_MS / 1000;
  localparam longint VSAMPLE_CYC = CLK_HZ * VSAMPLE_MS / 1000;
  typedef enum logic [1:0] {ACT_IDLE, ACT_CHARGE, ACT_DISCHARGE} activity_t;
endpackage

// >>> test/gauge_checker.sv
// assertion checker bound to the capacity gauge register bank
module gauge_checker
  import gauge_pkg::*;
#(
  parameter int unsigned OVERLOAD_FLAG_CYCLES = 20,
  parameter int unsigned SAMPLE_CYCLES = 10
) (
  input wire logic ref_clk, // clock
  input wire logic reset, // async reset
  input wire logic clk_en, // run enable
  input wire logic soft_reset, // soft reset
  input wire logic charge_pulse, // charge pin
  input wire logic above_charge_thresh, // charge qualifier
  input wire logic [2:0] rate_class, // rate pins
  input wire logic [4:0] seg_pulldown, // pull-downs
  input wire logic [4:0] seg_pullup, // pull-ups
  input wire logic reg_wr, // write strobe
  input wire logic [5:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata_q, // read data
  input wire logic first_empty_warning_q, // first empty
  input wire logic final_empty_warning_q, // final empty
  input wire logic learned_value_stale_flag_q // stale flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helper counters
  logic [3:0] cause_q, hi_run_q, still_q;
  logic [9:0] seg_last_q;
  // causes stay visible a while so the pin synchronisers are covered
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cause_q <= 4'h0;
      hi_run_q <= 4'h0;
      still_q <= 4'h0;
      seg_last_q <= 10'h000;
    end else begin
      if (soft_reset || charge_pulse || above_charge_thresh ||
          (reg_wr && reg_addr == ADDR_LEARNED)) begin
        cause_q <= 4'hC;
      end else if (clk_en && cause_q != 4'h0) begin
        cause_q <= cause_q - 4'h1;
      end
      if (rate_class != 3'h2) begin
        hi_run_q <= 4'h0;
      end else if (clk_en && hi_run_q != 4'hF) begin
        hi_run_q <= hi_run_q + 4'h1;
      end
      seg_last_q <= {seg_pulldown, seg_pullup};
      if (seg_last_q != {seg_pulldown, seg_pullup}) begin
        still_q <= 4'h0;
      end else if (still_q != 4'hF) begin
        still_q <= still_q + 4'h1;
      end
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  chk_stale_on_reset: assert property (
    ($past(reset) || $past(soft_reset && clk_en)) |=> learned_value_stale_flag_q)
    else $error("stale flag low after a reset");
  chk_stale_cause: assert property (
    !$stable(learned_value_stale_flag_q) |-> cause_q != 4'h0)
    else $error("stale flag moved with no charge, reset or learn");
  chk_empty_latched: assert property (
    ($fell(first_empty_warning_q) || $fell(final_empty_warning_q)) |-> cause_q != 4'h0)
    else $error("empty warning dropped without a valid charge");
  chk_overload_flag_no_empty: assert property (
    hi_run_q >= 4'h5 |-> !$rose(first_empty_warning_q) && !$rose(final_empty_warning_q))
    else $error("empty warning latched during overload");
  chk_rw_readback: assert property (
    (clk_en && reg_wr && (reg_addr == ADDR_PACK_TAG || reg_addr == ADDR_THRESH))
    ##1 (clk_en && !reg_wr && $stable(reg_addr)) |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("written byte not read back");
  chk_unmapped_zero: assert property (
    clk_en && reg_addr == 6'h20 |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  chk_pulldown_map: assert property (
    clk_en && reg_addr == ADDR_PULLDOWN && still_q > 4'h4 |=>
    reg_rdata_q[4:0] == $past(seg_pulldown))
    else $error("pull-down bits misplaced");
  chk_pullup_map: assert property (
    clk_en && reg_addr == ADDR_PULLUP && still_q > 4'h4 |=> reg_rdata_q[4:0] == $past(seg_pullup))
    else $error("pull-up bits misplaced");
endmodule // gauge_checker

bind capacity_gauge_register_bank gauge_checker #(
  .OVERLOAD_FLAG_CYCLES(OVERLOAD_FLAG_CYCLES), .SAMPLE_CYCLES(SAMPLE_CYCLES)
) chk_inst (
  .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .soft_reset(soft_reset),
  .charge_pulse(charge_pulse), .above_charge_thresh(above_charge_thresh),
  .rate_class(rate_class), .seg_pulldown(seg_pulldown), .seg_pullup(seg_pullup),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .first_empty_warning_q(first_empty_warning_q), .final_empty_warning_q(final_empty_warning_q),
  .learned_value_stale_flag_q(learned_value_stale_flag_q)
);

// >>> test/host_model.sv
// host controller model on the gauge register port
module host_model
  import gauge_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic [7:0] reg_rdata_q, // read data
  output logic reg_wr, // write strobe
  output logic [5:0] reg_addr, // address
  output logic [7:0] reg_wdata // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  task automatic write_reg(input logic [5:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= (addr == ADDR_FLAGS2) ? (data & 8'h7D) : data;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // released data shows the inverse
    reg_wdata <= ~data;
  endtask
  task automatic read_reg(input logic [5:0] addr, output logic [7:0] data);
    @(posedge ref_clk);
    reg_addr <= addr;
    repeat (2) @(posedge ref_clk);
    #1;
    data = (addr == ADDR_FLAGS2) ? (reg_rdata_q & 8'hF7) : reg_rdata_q;
  endtask
endmodule // host_model

// >>> test/tb_top.sv
// self-checking testbench for the capacity gauge register bank
module tb_top
  import gauge_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned OVERLOAD_FLAG_SIM = 20;
  localparam int unsigned SAMPLE_SIM = 10;
  logic ref_clk, reset, clk_en, soft_reset, charge_pulse, discharge_pulse, self_dis_pulse;
  logic above_charge_thresh, temp_below_zero, temp_below_ten, reg_wr;
  logic [2:0] rate_class;
  logic [4:0] seg_pulldown, seg_pullup;
  logic [5:0] reg_addr;
  logic [7:0] cell_sample, rate_comp_count, temp_comp_count, programmed_full_count;
  logic [7:0] reg_wdata, reg_rdata_q;
  logic first_empty_warning_q, final_empty_warning_q, learned_value_stale_flag_q;
  logic valid_discharge_flag_q;
  int err_total, tests_run;
  capacity_gauge_register_bank #(.OVERLOAD_FLAG_CYCLES(OVERLOAD_FLAG_SIM), .SAMPLE_CYCLES(SAMPLE_SIM)) DUT (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .soft_reset(soft_reset),
    .charge_pulse(charge_pulse), .discharge_pulse(discharge_pulse),
    .self_dis_pulse(self_dis_pulse), .above_charge_thresh(above_charge_thresh),
    .rate_class(rate_class), .temp_below_zero(temp_below_zero), .temp_below_ten(temp_below_ten),
    .cell_sample(cell_sample), .rate_comp_count(rate_comp_count),
    .temp_comp_count(temp_comp_count), .seg_pulldown(seg_pulldown), .seg_pullup(seg_pullup),
    .programmed_full_count(programmed_full_count), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .first_empty_warning_q(first_empty_warning_q), .final_empty_warning_q(final_empty_warning_q),
    .learned_value_stale_flag_q(learned_value_stale_flag_q),
    .valid_discharge_flag_q(valid_discharge_flag_q)
  );
  host_model host (.ref_clk(ref_clk), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // ==========================================================
  // shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic read_expect(input logic [5:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] v;
    host.read_reg(a, v);
    check(v & mask, exp);
  endtask
  task automatic pulses(input bit chg, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if (chg) charge_pulse <= 1'b1;
      else discharge_pulse <= 1'b1;
      repeat (2) @(posedge ref_clk);
      charge_pulse <= 1'b0;
      discharge_pulse <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic soft_rst();
    @(posedge ref_clk);
    soft_reset <= 1'b1;
    @(posedge ref_clk);
    soft_reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  // waits, then compares both empty flags
  task automatic empty_expect(input int cycles, input logic [7:0] exp);
    repeat (cycles) @(posedge ref_clk);
    #1;
    check({6'h00, first_empty_warning_q, final_empty_warning_q}, exp);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    soft_rst();
    read_expect(ADDR_NAC_HIGH, 8'hFF, 8'h00);
    read_expect(ADDR_NAC_LOW, 8'hFF, 8'h00);
    read_expect(ADDR_LEARNED, 8'hFF, programmed_full_count);
    read_expect(ADDR_THRESH, 8'hFF, 8'hA2);
    read_expect(ADDR_PULLDOWN, 8'h1F, 8'h09);
    read_expect(ADDR_PULLUP, 8'h1F, 8'h14);
    read_expect(ADDR_CHARGES, 8'hFF, 8'h00);
    read_expect(6'h20, 8'hFF, 8'h00);
    check({7'h00, learned_value_stale_flag_q}, 8'h01);
    $display("test reset_values done");
  endtask
  task automatic t_host_regs();
    host.write_reg(ADDR_PACK_TAG, 8'h5A);
    read_expect(ADDR_PACK_TAG, 8'hFF, 8'h5A);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    host.write_reg(ADDR_PACK_TAG, 8'h33);
    clk_en <= 1'b1;
    read_expect(ADDR_PACK_TAG, 8'hFF, 8'h5A);
    host.write_reg(ADDR_THRESH, 8'h81);
    read_expect(ADDR_THRESH, 8'hFF, 8'h81);
    host.write_reg(ADDR_PULLDOWN, 8'hFF);
    host.write_reg(ADDR_CHARGES, 8'h3F);
    @(posedge ref_clk);
    seg_pulldown <= 5'h12;
    seg_pullup <= 5'h0D;
    repeat (4) @(posedge ref_clk);
    read_expect(ADDR_PULLDOWN, 8'h1F, 8'h12);
    read_expect(ADDR_PULLUP, 8'h1F, 8'h0D);
    read_expect(ADDR_CHARGES, 8'hFF, 8'h00);
    host.write_reg(ADDR_THRESH, 8'hA2);
    $display("test host_regs done");
  endtask
  task automatic t_counting();
    logic [7:0] first, later;
    @(posedge ref_clk);
    above_charge_thresh <= 1'b1;
    host.write_reg(ADDR_NAC_HIGH, 8'h00);
    host.write_reg(ADDR_NAC_LOW, 8'h10);
    pulses(1'b1, 3);
    read_expect(ADDR_NAC_LOW, 8'hFF, 8'h13);
    read_expect(ADDR_FLAGS2, 8'h04, 8'h04);
    @(posedge ref_clk);
    above_charge_thresh <= 1'b0;
    pulses(1'b0, 2);
    read_expect(ADDR_NAC_LOW, 8'hFF, 8'h11);
    @(posedge ref_clk);
    self_dis_pulse <= 1'b1;
    @(posedge ref_clk);
    self_dis_pulse <= 1'b0;
    repeat (4) @(posedge ref_clk);
    read_expect(ADDR_NAC_LOW, 8'hFF, 8'h10);
    host.read_reg(ADDR_RATE_CAP, first);
    @(posedge ref_clk);
    rate_comp_count <= 8'hF0;
    pulses(1'b0, 1);
    host.read_reg(ADDR_RATE_CAP, later);
    check({7'h00, later > first}, 8'h00);
    soft_rst();
    read_expect(ADDR_NAC_LOW, 8'hFF, 8'h00);
    host.write_reg(ADDR_NAC_HIGH, 8'h40);
    pulses(1'b0, 1);
    check({7'h00, valid_discharge_flag_q}, 8'h01);
    $display("test counting done");
  endtask
  task automatic t_rate_flags();
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      rate_class <= 3'(i);
      repeat (6) @(posedge ref_clk);
      read_expect(ADDR_FLAGS2, 8'h70, {1'b0, 3'(i), 4'h0});
    end
    read_expect(ADDR_FLAGS2, 8'h01, 8'h01);
    @(posedge ref_clk);
    rate_class <= 3'h0;
    repeat (6) @(posedge ref_clk);
    read_expect(ADDR_FLAGS2, 8'h01, 8'h01);
    repeat (OVERLOAD_FLAG_SIM + 6) @(posedge ref_clk);
    read_expect(ADDR_FLAGS2, 8'h01, 8'h00);
    $display("test rate_flags done");
  endtask
  task automatic t_empty();
    @(posedge ref_clk);
    rate_class <= 3'h2;
    cell_sample <= 8'hA0;
    empty_expect(SAMPLE_SIM + 8, 8'h00);
    read_expect(ADDR_CELL_V, 8'hFF, 8'hA0);
    @(posedge ref_clk);
    rate_class <= 3'h0;
    empty_expect(OVERLOAD_FLAG_SIM + SAMPLE_SIM + 10, 8'h02);
    @(posedge ref_clk);
    cell_sample <= 8'h90;
    empty_expect(SAMPLE_SIM + 8, 8'h03);
    @(posedge ref_clk);
    cell_sample <= 8'hC0;
    empty_expect(SAMPLE_SIM + 8, 8'h03);
    @(posedge ref_clk);
    above_charge_thresh <= 1'b1;
    pulses(1'b1, 1);
    empty_expect(1, 8'h00);
    read_expect(ADDR_LEARNED, 8'hFF, 8'h3C);
    check({6'h00, learned_value_stale_flag_q, valid_discharge_flag_q}, 8'h00);
    $display("test empty done");
  endtask
  // ==========================================================
  // run control
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    {soft_reset, charge_pulse, discharge_pulse, self_dis_pulse, above_charge_thresh} = '0;
    {temp_below_zero, temp_below_ten, rate_class} = '0;
    reset = 1'b1;
    clk_en = 1'b1;
    cell_sample = 8'hC0;
    rate_comp_count = 8'h20;
    temp_comp_count = 8'h18;
    programmed_full_count = 8'h40;
    seg_pulldown = 5'h09;
    seg_pullup = 5'h14;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_values();
    t_host_regs();
    t_counting();
    t_rate_flags();
    t_empty();
    report_and_stop();
  end
  // the scenarios need well under a thousand cycles
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule // tb_top
